// >>> hw/spi_interface_config_regs.v
// serial register interface with the two interface configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "ifcfg_regs.vh"
module spi_interface_config_regs (
   input wire ref_clk,
   input wire rst_n,
   input wire cs_n,
   input wire sclk,
   input wire sdi,
   output reg sdo,
   output reg sdo_oe,
   output reg soft_reset_pulse,
   output reg addr_ascending,
   output reg single_instr_mode,
   output reg short_addr_mode,
   output reg [7:0] loop_length
);
   // ==========================================================
   // states and storage
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_INSTR = 2'b01;
   localparam [1:0] ST_DATA = 2'b10;
   localparam [1:0] ST_HOLD = 2'b11;

   reg [1:0] state_r;
   reg [3:0] bit_cnt_r;
   reg [14:0] shift_in_r;
   reg rd_r;
   reg [14:0] addr_r;
   reg [14:0] start_r;
   reg [7:0] cnt_r;
   reg [7:0] cfg_a_r;
   reg [7:0] cfg_b_r;
   reg [7:0] loop_r;
   reg [7:0] tx_r;
   reg sclk_q;
   reg [14:0] instr_addr;
   reg [7:0] rx_byte;
   wire [14:0] step_addr;
   wire [7:0] step_cnt;
   wire sclk_rise;
   wire sclk_fall;
   wire short_mode;
   wire [3:0] instr_last;

   // ==========================================================
   // readback decode, shared by the instruction and data paths
   function [7:0] read_reg;
      input [14:0] a;
      input [7:0] ra;
      input [7:0] rb;
      input [7:0] rl;
      begin
         case (a)
            // reserved bits read zero, enable status is a constant one
            `ADDR_IF_A: read_reg = (ra & `A_WR_MASK) | 8'h10;
            `ADDR_IF_B: read_reg = rb & `B_WR_MASK;
            `ADDR_LOOP: read_reg = rl;
            default: read_reg = 8'h00;
         endcase
      end
   endfunction

   assign sclk_rise = sclk & ~sclk_q;
   assign sclk_fall = ~sclk & sclk_q;
   assign short_mode = cfg_b_r[`B_SHORT];
   assign instr_last = short_mode ? `SHORT_INSTR_LAST : `LONG_INSTR_LAST;

   always @* begin
      instr_addr = {shift_in_r[13:0], sdi} &
         (short_mode ? `SHORT_ADDR_MASK : `LONG_ADDR_MASK);
      rx_byte = {shift_in_r[6:0], sdi};
   end

   addr_stepper u_step (
      .addr(addr_r),
      .start_addr(start_r),
      .ascending(cfg_a_r[`A_DIR]),
      .short_mode(short_mode),
      .loop_len(loop_r),
      .byte_cnt(cnt_r),
      .next_addr(step_addr),
      .next_cnt(step_cnt)
   );

   // ==========================================================
   // frame engine: instruction phase then data bytes
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_in_r <= 15'h0000;
         rd_r <= 1'b0;
         addr_r <= 15'h0000;
         start_r <= 15'h0000;
         cnt_r <= 8'h00;
         cfg_a_r <= `RST_IF_A;
         cfg_b_r <= `RST_IF_B;
         loop_r <= `RST_LOOP;
         tx_r <= 8'h00;
         sclk_q <= 1'b0;
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
         soft_reset_pulse <= 1'b0;
      end else begin
         sclk_q <= sclk;
         soft_reset_pulse <= 1'b0;
         if (cs_n) begin
            // deselect ends the frame wherever it stands
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            sdo_oe <= 1'b0;
            sdo <= 1'b0;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  state_r <= ST_INSTR;
                  bit_cnt_r <= 4'h0;
                  if (sclk_rise) begin
                     rd_r <= sdi;
                     shift_in_r <= {14'h0000, sdi};
                     bit_cnt_r <= 4'h1;
                  end
               end
               ST_INSTR: begin
                  if (sclk_rise) begin
                     shift_in_r <= {shift_in_r[13:0], sdi};
                     if (bit_cnt_r == 4'h0) begin
                        rd_r <= sdi;
                     end
                     if (bit_cnt_r == instr_last) begin
                        state_r <= ST_DATA;
                        bit_cnt_r <= 4'h0;
                        addr_r <= instr_addr;
                        start_r <= instr_addr;
                        cnt_r <= 8'h00;
                        tx_r <= read_reg(instr_addr, cfg_a_r, cfg_b_r, loop_r);
                        sdo_oe <= rd_r;
                     end else begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                     end
                  end
               end
               ST_DATA: begin
                  if (sclk_fall && rd_r) begin
                     // data changes on the falling edge, ready for the next rise
                     sdo <= tx_r[7];
                     tx_r <= {tx_r[6:0], 1'b0};
                  end
                  if (sclk_rise) begin
                     shift_in_r <= {shift_in_r[13:0], sdi};
                     if (bit_cnt_r == `BYTE_LAST) begin
                        bit_cnt_r <= 4'h0;
                        if (!rd_r) begin
                           case (addr_r)
                              `ADDR_IF_A: begin
                                 // reset bits self-clear; only direction is kept
                                 cfg_a_r <= rx_byte & 8'h20;
                                 if (rx_byte[`A_RST_HI] && rx_byte[`A_RST_LO]) begin
                                    cfg_b_r <= `RST_IF_B;
                                    loop_r <= `RST_LOOP;
                                    soft_reset_pulse <= 1'b1;
                                 end
                              end
                              `ADDR_IF_B: cfg_b_r <= rx_byte & `B_WR_MASK;
                              `ADDR_LOOP: loop_r <= rx_byte;
                              default: begin
                              end
                           endcase
                        end
                        if (cfg_b_r[`B_SINGLE]) begin
                           // one byte per instruction; later clocks are ignored
                           state_r <= ST_HOLD;
                        end else begin
                           addr_r <= step_addr;
                           cnt_r <= step_cnt;
                           tx_r <= read_reg(step_addr, cfg_a_r, cfg_b_r, loop_r);
                        end
                     end else begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                     end
                  end
               end
               ST_HOLD: begin
                  if (sclk_fall) begin
                     sdo_oe <= 1'b0;
                     sdo <= 1'b0;
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // ==========================================================
   // configuration seen by the rest of the device
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_ascending <= 1'b0;
         single_instr_mode <= 1'b0;
         short_addr_mode <= 1'b1;
         loop_length <= 8'h00;
      end else begin
         addr_ascending <= cfg_a_r[`A_DIR];
         single_instr_mode <= cfg_b_r[`B_SINGLE];
         short_addr_mode <= cfg_b_r[`B_SHORT];
         loop_length <= loop_r;
      end
   end
endmodule
`default_nettype wire

// >>> hw/ifcfg_regs.vh
// register map constants for the serial interface configuration block
// What this block does
// - a write to config A with bits 7 and 0 both set resets other registers
// - only one reset bit set in a write does nothing
// - direction bit 5: 0 steps address down, 1 steps it up per data byte
// - access mode bit 7 of config B at 0 selects streaming with address stepping
// - access mode bit at 1 selects single instruction mode
// - config B bit 3: 1 means 7-bit address, 0 means 15-bit address
// - config A sits at 0x00, resets to 0x10, data-out enable reads 1
// - config B sits at 0x01, resets to 0x08
// - nonzero loop length returns address to start after that many bytes
`ifndef IFCFG_REGS_VH
`define IFCFG_REGS_VH
`define ADDR_IF_A 15'h0000
`define ADDR_IF_B 15'h0001
`define ADDR_LOOP 15'h000E
`define RST_IF_A 8'h10
`define RST_IF_B 8'h08
`define RST_LOOP 8'h00
`define A_RST_HI 7
`define A_DIR 5
`define A_SDO_EN 4
`define A_RST_LO 0
`define B_SINGLE 7
`define B_SHORT 3
`define A_WR_MASK 8'h21
`define B_WR_MASK 8'h88
`define SHORT_ADDR_MASK 15'h007F
`define LONG_ADDR_MASK 15'h7FFF
`define SHORT_INSTR_LAST 4'h7
`define LONG_INSTR_LAST 4'hF
`define BYTE_LAST 4'h7
`endif

// >>> hw/addr_stepper.v
// address step logic for multibyte and streaming access
`timescale 1ns/1ps
`default_nettype none
module addr_stepper (
   input wire [14:0] addr,
   input wire [14:0] start_addr,
   input wire ascending,
   input wire short_mode,
   input wire [7:0] loop_len,
   input wire [7:0] byte_cnt,
   output reg [14:0] next_addr,
   output reg [7:0] next_cnt
);
   reg [14:0] stepped;
   always @* begin
      next_cnt = byte_cnt + 8'h01;
      if (ascending) begin
         stepped = addr + 15'h0001;
      end else begin
         stepped = addr - 15'h0001;
      end
      // zero loop length lets the address wrap at the edge of the address space
      if ((loop_len != 8'h00) && (next_cnt == loop_len)) begin
         next_addr = start_addr;
         next_cnt = 8'h00;
      end else begin
         next_addr = stepped & (short_mode ? `SHORT_ADDR_MASK : `LONG_ADDR_MASK);
      end
   end
endmodule
`default_nettype wire

// >>> bench/ifcfg_asserts.sv
// checker for the interface configuration block
`timescale 1ns/1ps
`default_nettype none
module ifcfg_asserts (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic soft_reset_pulse,
   input wire logic addr_ascending,
   input wire logic single_instr_mode,
   input wire logic short_addr_mode,
   input wire logic [7:0] loop_length
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // two idle samples: the frame is over and the pin is let go
   sequence idle_two;
      cs_n ##1 cs_n;
   endsequence
   a_pulse_one_cycle: assert property (soft_reset_pulse |=> !soft_reset_pulse)
      else $error("reset pulse too long");
   // the mode outputs trail the registers by one cycle, so look one cycle after the pulse
   a_reset_gives_defaults: assert property (soft_reset_pulse |=>
      !single_instr_mode && short_addr_mode && loop_length == 8'h00) else $error("bad defaults");
   a_pulse_in_frame: assert property (soft_reset_pulse |-> !$past(cs_n))
      else $error("pulse outside a write");
   a_oe_idle_off: assert property (idle_two |-> !sdo_oe) else $error("oe while idle");
   a_dir_held_idle: assert property ($changed(addr_ascending) |-> !$past(cs_n, 2))
      else $error("direction moved");
   a_mode_held_idle: assert property ($changed(single_instr_mode) |-> !$past(cs_n))
      else $error("mode moved");
   a_short_held_idle: assert property ($changed(short_addr_mode) |-> !$past(cs_n))
      else $error("addr length moved");
   a_loop_held_idle: assert property ($changed(loop_length) |-> !$past(cs_n))
      else $error("loop length moved");
endmodule
bind spi_interface_config_regs ifcfg_asserts ifcfg_asserts_inst (.ref_clk, .rst_n, .cs_n, .sclk,
   .sdi, .sdo, .sdo_oe, .soft_reset_pulse, .addr_ascending, .single_instr_mode, .short_addr_mode,
   .loop_length);
`default_nettype wire

// >>> bench/host_spi_model.sv
// behavioural host controller for the serial register interface
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
   input wire logic ref_clk,
   input wire logic sdo,
   output logic cs_n,
   output logic sclk,
   output logic sdi
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // sclk low spans two ref_clk samples and sclk high three, so the edge detector sees each half
   task automatic bit_io(input logic b, output logic o);
      @(posedge ref_clk);
      sclk <= 1'b0;
      sdi <= b;
      repeat (2) @(posedge ref_clk);
      sclk <= 1'b1;
      @(posedge ref_clk);
      o = sdo;
      @(posedge ref_clk);
   endtask
   task automatic frame(input logic rd, input logic [14:0] a, input logic shrt, input int n,
      input logic [31:0] wd, output logic [31:0] q);
      int i;
      logic o;
      q = 32'h0;
      @(posedge ref_clk);
      cs_n <= 1'b0;
      bit_io(rd, o);
      for (i = shrt ? 6 : 14; i >= 0; i--)
         bit_io(a[i], o);
      for (i = n * 8 - 1; i >= 0; i--) begin
         bit_io(wd[i], o);
         q[i] = o;
      end
      @(posedge ref_clk);
      sclk <= 1'b0;
      // a released line must not keep its last value
      sdi <= ~sdi;
      repeat (2) @(posedge ref_clk);
      cs_n <= 1'b1;
      @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// >>> bench/spi_interface_config_regs_tb.sv
// self-checking testbench for the interface configuration block
`timescale 1ns/1ps
`default_nettype none
module spi_interface_config_regs_tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic shrt = 1'b1;
   wire logic cs_n, sclk, sdi, sdo, sdo_oe, soft_reset_pulse;
   wire logic addr_ascending, single_instr_mode, short_addr_mode;
   wire logic [7:0] loop_length;
   int err_total = 0;
   int checked = 0;
   int pulses = 0;
   int oe_cycles = 0;
   int oe_mark = 0;
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (soft_reset_pulse === 1'b1) pulses <= pulses + 1;
   always @(posedge ref_clk) if (sdo_oe === 1'b1) oe_cycles <= oe_cycles + 1;
   spi_interface_config_regs spi_interface_config_regs_inst (.ref_clk, .rst_n, .cs_n, .sclk,
      .sdi, .sdo, .sdo_oe, .soft_reset_pulse, .addr_ascending, .single_instr_mode,
      .short_addr_mode, .loop_length);
   host_spi_model host_spi_model_inst (.ref_clk, .sdo, .cs_n, .sclk, .sdi);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask
   task automatic xf(input logic r, input logic [14:0] a, input int n, input logic [31:0] d,
      input logic [31:0] e, input string nm);
      logic [31:0] q;
      host_spi_model_inst.frame(r, a, shrt, n, d, q);
      if (r) chk(nm, e, q);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      xf(1, 15'h0000, 1, 0, 32'h10, "cfg_a");
      xf(1, 15'h0001, 1, 0, 32'h08, "cfg_b");
      // let the counter take the last enabled cycle of the read frame
      @(posedge ref_clk);
      chk("oe_read", 1, oe_cycles > 0);
      oe_mark = oe_cycles;
      xf(0, 15'h0000, 1, 32'h80, 0, "");
      xf(0, 15'h0000, 1, 32'h01, 0, "");
      chk("no_pulse", 0, pulses);
      chk("oe_write", oe_mark, oe_cycles);
      xf(0, 15'h0001, 1, 32'h88, 0, "");
      xf(0, 15'h000E, 1, 32'h05, 0, "");
      xf(0, 15'h0000, 1, 32'h81, 0, "");
      chk("pulse", 1, pulses);
      chk("defaults", 10'h100, {single_instr_mode, short_addr_mode, loop_length});
      xf(1, 15'h0000, 1, 0, 32'h10, "a_kept");
      $display("test soft_reset done");
      xf(0, 15'h0000, 1, 32'hEE, 0, "");
      xf(1, 15'h0000, 1, 0, 32'h30, "a_mask");
      xf(0, 15'h0001, 1, 32'h7F, 0, "");
      xf(1, 15'h0000, 2, 0, 32'h3008, "stream_up");
      xf(0, 15'h0000, 1, 32'h00, 0, "");
      xf(1, 15'h0001, 2, 0, 32'h0810, "stream_down");
      xf(0, 15'h0000, 1, 32'h20, 0, "");
      chk("dir", 1, addr_ascending);
      xf(0, 15'h000E, 1, 32'h02, 0, "");
      xf(1, 15'h0000, 3, 0, 32'h300830, "loop");
      xf(0, 15'h000E, 1, 32'h00, 0, "");
      $display("test streaming done");
      xf(0, 15'h0001, 1, 32'h88, 0, "");
      xf(0, 15'h0000, 2, 32'h2000, 0, "");
      xf(1, 15'h0001, 1, 0, 32'h88, "single");
      xf(0, 15'h0001, 1, 32'h00, 0, "");
      shrt = 1'b0;
      chk("long_mode", 0, short_addr_mode);
      xf(1, 15'h7F00, 1, 0, 32'h00, "long_unmapped");
      xf(0, 15'h0001, 1, 32'h08, 0, "");
      shrt = 1'b1;
      xf(1, 15'h0001, 1, 0, 32'h08, "b_short");
      $display("test modes done");
      finish_test();
   end
endmodule
`default_nettype wire
